// [hdl/adc_cal_defs.svh]
// Purpose: Shared constants for the converter calibration link
// Assumes: Included by bare name from the package
// Notes:   Offsets are byte addresses of the host register port
`ifndef ADC_CAL_DEFS_SVH
`define ADC_CAL_DEFS_SVH

// Widths and period multiplier
`define COEF_W         24
`define RATE_W         10
`define PER_W          5
`define FRAC_BITS      23
`define PERIOD_MUL_DEF 1024

// Operating-mode field codes
`define MD_CONT     3'h0
`define MD_SINGLE   3'h1
`define MD_IDLE     3'h2
`define MD_PDOWN    3'h3
`define MD_INT_ZERO 3'h4
`define MD_INT_FULL 3'h5
`define MD_SYS_ZERO 3'h6
`define MD_SYS_FULL 3'h7

// Settling lengths in output periods
`define SETTLE_SINC4   5'h04
`define SETTLE_SINC3   5'h03
`define SETTLE_CHOP_IZ 5'h02

// Reset values
`define RATE_RST 10'h060
`define OFFS_RST 24'h000000
`define FULL_RST 24'h800000

// Host register byte offsets
`define A_MODE   5'h00
`define A_CFG    5'h04
`define A_OFFS   5'h08
`define A_FULL   5'h0C
`define A_STATUS 5'h10
`define A_DATA   5'h14

// Field positions
`define MODE_CS_BIT  8
`define ST_RDY       0
`define ST_PIN       1
`define ST_DONE      2
`define ST_REFUSED   3
`define ST_ZERO_DONE 4
`endif

// [hdl/adc_cal_pkg.sv]
// Purpose: Types shared by both link ends
// Assumes: Constants come from the defs header
// Notes:   Filter setting travels as one packed word
package adc_cal_pkg;
`include "adc_cal_defs.svh"

  // Filter and rate setting, top bit downward
  typedef struct packed {
    logic                 clk_div;
    logic                 gain_hi;
    logic                 avg_en;
    logic                 zero_lat;
    logic                 chop;
    logic                 sinc3;
    logic [`RATE_W-1:0]   rate_div;
  } cfg_s;

  typedef logic [2:0] mode_t;

  // Device sequencer states
  typedef enum logic [2:0] {
    D_CONV = 3'b001,
    D_CAL  = 3'b010,
    D_HALT = 3'b100
  } dev_st_e;
endpackage

// [hdl/cal_link_if.sv]
// Purpose: Parallel control link between host and converter
// Assumes: One clock, all signals synchronous
// Notes:   Ready pin is an output with enable, low enable drives
`timescale 1ns/1ps
interface cal_link_if import adc_cal_pkg::*; ();
  logic                 mode_wr;       // Mode field write strobe
  mode_t                mode_val;      // Mode field value
  logic                 cfg_wr;        // Configuration write strobe
  cfg_s                 cfg;           // Configuration value
  logic                 coef_wr;       // Coefficient write strobe
  logic                 coef_sel;      // 0 offset, 1 full-scale
  logic [`COEF_W-1:0]   coef_wdata;    // Coefficient write value
  logic [`COEF_W-1:0]   offs_coef;     // Offset coefficient readback
  logic [`COEF_W-1:0]   full_coef;     // Full-scale coefficient readback
  logic [`COEF_W-1:0]   conv_data;     // Corrected conversion data
  logic                 rdy_flag;      // High means not ready
  logic                 dout_rdy;      // Data-out/ready pin value
  logic                 dout_rdy_oe_n; // Pin driven while low
  logic                 cs_n;          // Chip select, active low

  modport dev  (input mode_wr, mode_val, cfg_wr, cfg, coef_wr, coef_sel,
                coef_wdata, cs_n,
                output offs_coef, full_coef, conv_data, rdy_flag,
                dout_rdy, dout_rdy_oe_n);
  modport host (output mode_wr, mode_val, cfg_wr, cfg, coef_wr, coef_sel,
                coef_wdata, cs_n,
                input offs_coef, full_coef, conv_data, rdy_flag,
                dout_rdy, dout_rdy_oe_n);
endinterface

// [hdl/cal_timer.sv]
// Purpose: Counts a number of output-data periods
// Assumes: One period is rate_div times PERIOD_MUL clocks
// Notes:   rate_div of zero is illegal and not guarded
`timescale 1ns/1ps
module cal_timer #(
  parameter int PERIOD_MUL = 1024,
  parameter int RW         = 10,
  parameter int PW         = 5
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Control
  input  wire logic          start,
  input  wire logic          stop,
  input  wire logic [RW-1:0] rate_div,
  input  wire logic [PW-1:0] periods,
  // Status
  output logic               busy,
  output logic               done
);
  localparam int CW = RW + $clog2(PERIOD_MUL);

  logic [CW-1:0] cyc_r;     // Clock count in the period
  logic [PW-1:0] per_r;     // Completed periods
  logic [CW-1:0] per_len;   // Clocks per output period
  wire           cyc_last;
  wire           per_last;

  assign per_len  = CW'(rate_div) * CW'(PERIOD_MUL);
  assign cyc_last = (cyc_r == per_len - CW'(1));
  assign per_last = (per_r == periods - PW'(1));
  assign done     = ce & busy & cyc_last & per_last;

  // Period and cycle counters
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy  <= 1'b0;
      cyc_r <= '0;
      per_r <= '0;
    end
    else if (ce)
    begin
      if (start | stop)
      begin
        busy  <= start;
        cyc_r <= '0;
        per_r <= '0;
      end
      else if (busy & cyc_last)
      begin
        cyc_r <= '0;
        per_r <= per_r + PW'(1);
        busy  <= ~per_last;
      end
      else if (busy)
        cyc_r <= cyc_r + CW'(1);
    end
  end
endmodule

// [hdl/adc_cal_device.sv]
// Purpose: Converter end: calibration sequencer and result correction
// Assumes: Filter datapath outside delivers raw results with a strobe
// Notes:   Master clock is core_clk gated by ce
`timescale 1ns/1ps
// Notes on behaviour
// - Four calibration modes from mode field
// - Calibration start drives flag and pin high
// - Completion updates coefficient, clears flag, idles
// - Result minus offset, then times full-scale
// - Internal calibrations route reference inputs
// - Host applies system levels before system calibration
// - Host does zero-scale before full-scale
// - Chop off: zero calibrations take settling
// - Chop on: internal zero two periods
// - Internal full-scale doubles above gain one
// - System full-scale takes one settling time
// - Internal full-scale needs rate divisible 16
// - Clock-halving bit doubles internal full-scale time
// - Coefficients written only when idle/power-down
// - Coefficients are 24-bit read/write registers
// - Host polls flag or watches pin fall
// - Mode or config write resets filter
// - Reset default sinc4, chop off
// - Sinc order, chop, latency, averaging options
// - Output rate is clock over 1024*divider
module adc_cal_device import adc_cal_pkg::*; #(
  parameter int PERIOD_MUL = `PERIOD_MUL_DEF,
  parameter int DW         = `COEF_W
) (
  // Clock, reset, enable
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Link to host
  cal_link_if.dev            link,
  // Raw results from the filter
  input  wire logic [DW-1:0] raw_data,
  input  wire logic          raw_valid,
  // Controls to the analog front and filter
  output logic               filter_resync,
  output logic               route_zero,
  output logic               route_full,
  output cfg_s               filter_cfg
);
  dev_st_e         st_r;        // Sequencer state
  dev_st_e         st_nxt;
  mode_t           mode_r;      // Current operating mode
  cfg_s            cfg_r;       // Latched filter setting
  logic [DW-1:0]   offs_r;      // Offset coefficient
  logic [DW-1:0]   full_r;      // Full-scale coefficient
  logic [DW-1:0]   data_r;      // Corrected data register
  logic [DW-1:0]   last_raw_r;  // Latest raw result
  logic            rdy_r;       // High while not ready
  logic            resync_r;    // Filter reset pulse
  logic [4:0]      settle_n;    // Settling periods, one time
  logic [4:0]      cal_n;       // Periods for requested mode
  logic            tmr_done;
  logic signed [DW:0]     diff;   // Raw minus offset
  logic signed [2*DW+1:0] prod;   // Scaled difference
  logic [DW-1:0]   scaled;

  // Decode of strobes and mode
  wire cfg_take  = link.cfg_wr | link.mode_wr;
  wire is_cal    = link.mode_val[2];
  wire cal_start = link.mode_wr & is_cal;
  wire run_start = link.mode_wr & ~is_cal &
                   (link.mode_val == `MD_CONT ||
                    link.mode_val == `MD_SINGLE);
  wire in_cal    = (st_r == D_CAL);
  wire data_take = raw_valid & (st_r == D_CONV) & ~resync_r;
  wire coef_ok   = link.coef_wr & ~in_cal;

  // Settling time of the latched filter setting
  assign settle_n = cfg_r.sinc3 ? `SETTLE_SINC3 : `SETTLE_SINC4;

  // Calibration length by mode
  always_comb
  begin
    cal_n = settle_n;
    case (mode_r)
      `MD_INT_ZERO:
        cal_n = cfg_r.chop ? `SETTLE_CHOP_IZ : settle_n;
      `MD_SYS_ZERO:
        cal_n = settle_n;
      `MD_INT_FULL:
      begin
        cal_n = cfg_r.gain_hi ? 5'(settle_n << 1) : settle_n;
        if (cfg_r.clk_div)
          cal_n = 5'(cal_n << 1);
      end
      `MD_SYS_FULL:
        cal_n = settle_n;
      default:
        cal_n = settle_n;
    endcase
  end

  // Output-period counter for calibration
  cal_timer #(
    .PERIOD_MUL (PERIOD_MUL),
    .RW         (`RATE_W),
    .PW         (`PER_W)
  ) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .start    (st_r == D_CAL && resync_r),
    .stop     (link.mode_wr & ~resync_r),
    .rate_div (cfg_r.rate_div),
    .periods  (cal_n),
    .busy     (),
    .done     (tmr_done)
  );

  // Correction of raw results
  assign diff   = $signed({1'b0, raw_data}) - $signed({1'b0, offs_r});
  assign prod   = diff * $signed({1'b0, full_r});
  assign scaled = prod[`FRAC_BITS +: DW];

  // Next state
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      D_CONV:
        if (data_take && mode_r == `MD_SINGLE)
          st_nxt = D_HALT;
      D_CAL:
        if (tmr_done)
          st_nxt = D_HALT;
      D_HALT:
        st_nxt = D_HALT;
      default:
        st_nxt = D_HALT;
    endcase
    if (cal_start)
      st_nxt = D_CAL;
    else if (run_start)
      st_nxt = D_CONV;
    else if (link.mode_wr)
      st_nxt = D_HALT;
  end

  // State, mode and setting
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r   <= D_CONV;
      mode_r <= `MD_CONT;
      cfg_r  <= '{rate_div: `RATE_RST, default: 1'b0};
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      if (link.mode_wr)
        mode_r <= link.mode_val;
      else if (in_cal && tmr_done)
        mode_r <= `MD_IDLE;
      if (cfg_take)
        cfg_r <= link.cfg;
    end
  end

  // Filter reset on any mode or setting write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      resync_r <= 1'b0;
    else if (ce)
      resync_r <= cfg_take;
  end

  // Ready flag: set on start, cleared on result
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdy_r <= 1'b1;
    else if (ce)
    begin
      if (cal_start)
        rdy_r <= 1'b1;
      else if (in_cal && tmr_done)
        rdy_r <= 1'b0;
      else if (link.mode_wr)
        rdy_r <= 1'b1;
      else if (data_take)
        rdy_r <= 1'b0;
    end
  end

  // Latest raw sample for calibration capture
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      last_raw_r <= '0;
    else if (ce && raw_valid)
      last_raw_r <= raw_data;
  end

  // Coefficient registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      offs_r <= `OFFS_RST;
      full_r <= `FULL_RST;
    end
    else if (ce)
    begin
      if (in_cal && tmr_done)
      begin
        if (!mode_r[0])
          offs_r <= last_raw_r;
        else
          full_r <= last_raw_r;
      end
      else if (coef_ok && !link.coef_sel)
        offs_r <= link.coef_wdata;
      else if (coef_ok)
        full_r <= link.coef_wdata;
    end
  end

  // Corrected data register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      data_r <= '0;
    else if (ce && data_take)
      data_r <= scaled;
  end

  // Reference routing during internal calibrations
  assign route_zero = in_cal & (mode_r == `MD_INT_ZERO);
  assign route_full = in_cal & (mode_r == `MD_INT_FULL);

  // Outputs
  assign filter_resync      = resync_r;
  assign filter_cfg         = cfg_r;
  assign link.offs_coef     = offs_r;
  assign link.full_coef     = full_r;
  assign link.conv_data     = data_r;
  assign link.rdy_flag      = rdy_r;
  assign link.dout_rdy      = rdy_r;
  assign link.dout_rdy_oe_n = link.cs_n;
endmodule

// [hdl/adc_cal_host.sv]
// Purpose: Host end: register port that orders calibrations
// Assumes: Read data stands in the cycle after the read strobe
// Notes:   Orders that break sequencing rules are refused
`timescale 1ns/1ps
module adc_cal_host import adc_cal_pkg::*; (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register port
  input  wire logic [4:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // Board conditions
  input  wire logic        avdd_low,
  input  wire logic        sys_level_ok,
  // Link to device
  cal_link_if.host         link
);
  cfg_s        cfg_r;        // Filter setting
  mode_t       mode_r;       // Last mode ordered
  logic        cs_r;         // Chip select asserted
  logic        done_r;       // Sticky completion
  logic        refused_r;    // Sticky refusal
  logic        zero_done_r;  // Zero-scale done since setting
  logic        pin_q_r;      // Previous pin level
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;

  // Decode
  wire   wr_mode = wr & (addr == `A_MODE);
  wire   wr_cfg  = wr & (addr == `A_CFG);
  wire   wr_offs = wr & (addr == `A_OFFS);
  wire   wr_full = wr & (addr == `A_FULL);
  wire   wr_stat = wr & (addr == `A_STATUS);
  mode_t req_md;
  assign req_md  = wdata[2:0];
  wire   req_cal = req_md[2];
  wire   bad_rate = (req_md == `MD_INT_FULL) &&
                    (cfg_r.rate_div[3:0] != 4'h0);
  wire   bad_seq  = req_md[0] & req_cal & ~zero_done_r;
  wire   bad_sys  = (req_md == `MD_SYS_ZERO ||
                     req_md == `MD_SYS_FULL) & ~sys_level_ok;
  wire   refuse_md = wr_mode & req_cal & (bad_rate | bad_seq | bad_sys);
  wire   go_md     = wr_mode & ~refuse_md;
  wire   quiet     = (mode_r == `MD_IDLE) || (mode_r == `MD_PDOWN);
  wire   coef_req  = wr_offs | wr_full;
  wire   refuse_cf = coef_req & ~quiet;
  wire   pin_lvl   = link.dout_rdy_oe_n | link.dout_rdy;
  wire   pin_fall  = pin_q_r & ~pin_lvl;
  wire   cal_end   = pin_fall & mode_r[2];
  // Low supply forces clock halving on an internal full-scale order
  wire   force_div = avdd_low & (req_md == `MD_INT_FULL);

  // Link drive
  assign link.mode_wr    = go_md & ce;
  assign link.mode_val   = req_md;
  assign link.cfg_wr     = wr_cfg & ce;
  assign link.cfg        = wr_cfg ? cfg_s'(wdata[15:0]) :
                           cfg_s'({cfg_r.clk_div | force_div,
                                   cfg_r[14:0]});
  assign link.coef_wr    = coef_req & ~refuse_cf & ce;
  assign link.coef_sel   = wr_full;
  assign link.coef_wdata = wdata[`COEF_W-1:0];
  assign link.cs_n       = ~cs_r;

  // Control registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r  <= '{rate_div: `RATE_RST, default: 1'b0};
      mode_r <= `MD_CONT;
      cs_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_cfg)
        cfg_r <= cfg_s'(wdata[15:0]);
      if (go_md)
      begin
        mode_r <= req_md;
        cs_r   <= wdata[`MODE_CS_BIT];
      end
      else if (cal_end)
        mode_r <= `MD_IDLE;
    end
  end

  // Sticky status; a new event wins over a clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_r      <= 1'b0;
      refused_r   <= 1'b0;
      zero_done_r <= 1'b0;
      pin_q_r     <= 1'b1;
    end
    else if (ce)
    begin
      pin_q_r   <= pin_lvl;
      done_r    <= cal_end |
                   (done_r & ~(wr_stat & wdata[`ST_DONE]));
      refused_r <= refuse_md | refuse_cf |
                   (refused_r & ~(wr_stat & wdata[`ST_REFUSED]));
      if (cal_end && !mode_r[0])
        zero_done_r <= 1'b1;
      else if (wr_cfg)
        zero_done_r <= 1'b0;
    end
  end

  // Read selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `A_MODE:   rd_mux = {23'h0, cs_r, 5'h00, mode_r};
      `A_CFG:    rd_mux = {16'h0000, cfg_r};
      `A_OFFS:   rd_mux = {8'h00, link.offs_coef};
      `A_FULL:   rd_mux = {8'h00, link.full_coef};
      `A_STATUS: rd_mux = {27'h0, zero_done_r, refused_r, done_r,
                           pin_lvl, link.rdy_flag};
      `A_DATA:   rd_mux = {8'h00, link.conv_data};
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else if (ce)
      rdata_r <= rd ? rd_mux : 32'h0000_0000;
  end

  assign rdata = rdata_r;
endmodule

// [tb/adc_cal_asserts.sv]
// Purpose: Concurrent checks on the host-to-converter link
// Assumes: Sees only link signals plus the clock and reset
// Notes:   Calibration length is rebuilt from the setting at the order
`timescale 1ns/1ps
module adc_cal_asserts import adc_cal_pkg::*; #(
  parameter int PERIOD_MUL = 1024
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Orders on the link
  input  wire logic               mode_wr,
  input  wire mode_t              mode_val,
  input  wire cfg_s               cfg,
  input  wire logic               coef_wr,
  input  wire logic               coef_sel,
  // Status on the link
  input  wire logic [`COEF_W-1:0] offs_coef,
  input  wire logic [`COEF_W-1:0] full_coef,
  input  wire logic [`COEF_W-1:0] conv_data,
  input  wire logic               rdy_flag,
  input  wire logic               dout_rdy,
  input  wire logic               dout_rdy_oe_n,
  input  wire logic               cs_n
);
  logic cal_r;  // Calibration running
  logic halt_r; // Idle after a finished calibration
  int   cnt_r;  // Cycles since the order
  int   exp_r;  // Expected length in cycles
  int   per_w;  // Output periods for the order now on the link

  // Chop sets internal zero to two periods; gain and clock halving double full
  assign per_w = (mode_val == 3'h4 && cfg.chop) ? 2 :
    (cfg.sinc3 ? 3 : 4) << ((mode_val == 3'h5) ?
    (int'(cfg.gain_hi) + int'(cfg.clk_div)) : 0);

  // Track calibration and the idle state after it
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      cal_r  <= 1'b0;
      halt_r <= 1'b0;
      cnt_r  <= 0;
      exp_r  <= 0;
    end
    else if (mode_wr)
    begin
      cal_r  <= mode_val[2];
      halt_r <= 1'b0;
      cnt_r  <= 0;
      exp_r  <= per_w * int'(cfg.rate_div) * PERIOD_MUL;
    end
    else
    begin
      cal_r  <= cal_r && rdy_flag;
      halt_r <= halt_r || (cal_r && !rdy_flag);
      cnt_r  <= cal_r ? cnt_r + 1 : cnt_r;
    end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  cal_start_a: assert property (
    mode_wr && mode_val[2] |=> rdy_flag && dout_rdy)
    else $error("ready not raised by calibration order");
  pin_drive_a: assert property (
    dout_rdy == rdy_flag && dout_rdy_oe_n == cs_n)
    else $error("ready pin does not follow flag and select");
  cal_len_a: assert property (
    cal_r && !rdy_flag |-> cnt_r >= exp_r && cnt_r <= exp_r + 4)
    else $error("calibration length wrong");
  cal_bound_a: assert property (cal_r |-> cnt_r <= exp_r + 4)
    else $error("calibration overran");
  conv_freeze_a: assert property (
    cal_r && !mode_wr |=> $stable(conv_data))
    else $error("data changed during calibration");
  halt_freeze_a: assert property (
    halt_r && !mode_wr |=> $stable(conv_data))
    else $error("data changed while idle");
  halt_ready_a: assert property (halt_r |-> !rdy_flag)
    else $error("flag high while idle after calibration");
  offs_cause_a: assert property (
    $changed(offs_coef) |-> ($past(coef_wr) && !$past(coef_sel))
    || (cal_r && !rdy_flag)) else $error("offset changed unasked");
  full_cause_a: assert property (
    $changed(full_coef) |-> ($past(coef_wr) && $past(coef_sel))
    || (cal_r && !rdy_flag)) else $error("full-scale changed unasked");

  // Main scenarios reached
  int_full_c: cover property (mode_wr && mode_val == 3'h5);
  cal_end_c: cover property (cal_r && !rdy_flag);
  coef_wr_c: cover property (coef_wr);
endmodule

// [tb/adc_calibration_control_tb.sv]
// Purpose: Self-checking bench for the calibration host and converter
// Assumes: PERIOD_MUL cut to 4 so output periods are short
// Notes:   Both ends face each other over one link interface
`timescale 1ns/1ps
module adc_calibration_control_tb import adc_cal_pkg::*; ();
  localparam int PM = 4;            // Clocks per rate step
  logic        core_clk     = 1'b0;
  logic        rst_n        = 1'b0;
  logic        ce           = 1'b1;
  logic [4:0]  addr         = 5'h00;
  logic [31:0] wdata        = 32'h0;
  logic        wr           = 1'b0;
  logic        rd           = 1'b0;
  logic [31:0] rdata;
  logic        avdd_low     = 1'b0;
  logic        sys_level_ok = 1'b1;
  logic [23:0] raw_data     = 24'h0;
  logic        raw_valid    = 1'b0;
  logic        filter_resync, route_zero, route_full;
  cfg_s        filter_cfg;
  logic [31:0] rv;                  // Last read value
  int          n_errors = 0, tests_run = 0, cyc = 0, rate = 0;

  cal_link_if link ();
  adc_cal_host u_adc_cal_host (.core_clk, .rst_n, .ce, .addr,
    .wdata, .wr, .rd, .rdata, .avdd_low, .sys_level_ok, .link(link));
  adc_cal_device #(.PERIOD_MUL(PM)) u_adc_cal_device (.core_clk, .rst_n,
    .ce, .link(link), .raw_data, .raw_valid, .filter_resync,
    .route_zero, .route_full, .filter_cfg);
  adc_cal_asserts #(.PERIOD_MUL(PM)) u_adc_cal_asserts (.core_clk,
    .rst_n, .mode_wr(link.mode_wr), .mode_val(link.mode_val),
    .cfg(link.cfg), .coef_wr(link.coef_wr), .coef_sel(link.coef_sel),
    .offs_coef(link.offs_coef), .full_coef(link.full_coef),
    .conv_data(link.conv_data), .rdy_flag(link.rdy_flag),
    .dout_rdy(link.dout_rdy), .dout_rdy_oe_n(link.dout_rdy_oe_n),
    .cs_n(link.cs_n));

  always #5 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_b(string nm, logic e, logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic reg_wr(logic [4:0] a, logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
    #1;
  endtask

  // Read data is taken in the cycle after the strobe
  task automatic reg_rd(logic [4:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task automatic set_mode(logic [31:0] d, logic res);
    reg_wr(`A_MODE, d);
    chk_b("mode_resync", res, filter_resync);
  endtask

  task automatic set_cfg(logic g, logic ch, logic s3, int r);
    logic [15:0] c;
    c = {1'b0, g, 2'b00, ch, s3, 10'(r)};
    rate = r;
    reg_wr(`A_CFG, {16'h0, c});
    chk_b("cfg_resync", 1'b1, filter_resync);
    chk("filter_cfg", {16'h0, c}, {16'h0, filter_cfg});
  endtask

  // Start a calibration with select on, time it, check the result
  task automatic run_cal(logic [2:0] m, int n, logic [23:0] v);
    int cnt;
    int t;
    cnt = 0;
    t = n * rate * PM;
    raw_data <= v;
    set_mode({23'h0, 1'b1, 5'h0, m}, 1'b1);
    chk_b("rdy_flag", 1'b1, link.rdy_flag);
    chk_b("dout_rdy", 1'b1, link.dout_rdy);
    chk_b("route_zero", m == `MD_INT_ZERO, route_zero);
    chk_b("route_full", m == `MD_INT_FULL, route_full);
    do
    begin
      @(posedge core_clk);
      cnt++;
      raw_valid <= (cnt == 3);
      #1;
    end
    while (link.dout_rdy === 1'b1 && cnt < 5000);
    chk_b("cal_len", 1'b1, cnt >= t && cnt <= t + 4);
    chk_b("dout_rdy_oe_n", 1'b0, link.dout_rdy_oe_n);
    @(posedge core_clk);
    raw_valid <= 1'b1;
    reg_rd(`A_STATUS);
    raw_valid <= 1'b0;
    chk("status", 32'h4, {29'h0, rv[2:0]});
    reg_rd(m[0] ? `A_FULL : `A_OFFS);
    chk("coef", {8'h0, v}, rv);
  endtask

  task automatic refuse(logic [2:0] m);
    set_mode({29'h0, m}, 1'b0);
    reg_rd(`A_STATUS);
    chk_b("refused", 1'b1, rv[3]);
    reg_wr(`A_STATUS, 32'h8);
  endtask

  task automatic t_reset();
    chk("cfg_rst", 32'h60, {16'h0, filter_cfg});
    reg_rd(`A_OFFS);
    chk("offs_rst", 32'h0, rv);
    reg_rd(`A_FULL);
    chk("full_rst", 32'h800000, rv);
  endtask

  task automatic t_coef();
    set_mode(`MD_IDLE, 1'b1);
    reg_wr(`A_OFFS, 32'h100);
    set_mode(`MD_PDOWN, 1'b1);
    reg_wr(`A_FULL, 32'h400000);
    reg_rd(`A_OFFS);
    chk("offs_rw", 32'h100, rv);
    chk("offs_link", 32'h100, {8'h0, link.offs_coef});
    reg_rd(`A_FULL);
    chk("full_rw", 32'h400000, rv);
    // A write with the enable low must leave the offset register alone
    ce <= 1'b0;
    reg_wr(`A_OFFS, 32'h55);
    ce <= 1'b1;
    reg_rd(`A_OFFS);
    chk("offs_frozen", 32'h100, rv);
    set_mode(`MD_CONT, 1'b1);
    reg_wr(`A_OFFS, 32'hABCDEF);
    reg_rd(`A_OFFS);
    chk("offs_busy", 32'h100, rv);
    reg_rd(`A_STATUS);
    chk_b("coef_refused", 1'b1, rv[3]);
    reg_wr(`A_STATUS, 32'h8);
  endtask

  // One raw result from the filter, one cycle long
  task automatic raw_pulse(logic [23:0] v);
    @(posedge core_clk);
    raw_data  <= v;
    raw_valid <= 1'b1;
    @(posedge core_clk);
    raw_valid <= 1'b0;
  endtask

  // Offset taken off first, then scaled by the full-scale gain:
  // (0x1100 - 0x100) * 0x400000 >> 23 is 0x800, 0x2100 gives 0x1000
  task automatic t_correct();
    raw_pulse(24'h1100);
    reg_rd(`A_DATA);
    chk("corrected", 32'h800, rv);
    set_mode(`MD_SINGLE, 1'b1);
    raw_pulse(24'h2100);
    raw_pulse(24'h3100);
    reg_rd(`A_DATA);
    chk("single_data", 32'h1000, rv);
  endtask

  task automatic t_cal();
    set_cfg(1'b0, 1'b0, 1'b0, 16);
    refuse(`MD_INT_FULL);
    run_cal(`MD_INT_ZERO, 4, 24'h000123);
    run_cal(`MD_INT_FULL, 4, 24'h7FF000);
    sys_level_ok <= 1'b0;
    refuse(`MD_SYS_ZERO);
    sys_level_ok <= 1'b1;
    run_cal(`MD_SYS_FULL, 4, 24'h7FFF00);
    set_cfg(1'b0, 1'b0, 1'b1, 16);
    run_cal(`MD_SYS_ZERO, 3, 24'h000045);
    set_cfg(1'b0, 1'b1, 1'b0, 16);
    run_cal(`MD_INT_ZERO, 2, 24'h000021);
    run_cal(`MD_SYS_ZERO, 4, 24'h000033);
    set_cfg(1'b1, 1'b0, 1'b0, 16);
    run_cal(`MD_INT_ZERO, 4, 24'h000011);
    run_cal(`MD_INT_FULL, 8, 24'h7F0000);
    avdd_low <= 1'b1;
    run_cal(`MD_INT_FULL, 16, 24'h7E0000);
    avdd_low <= 1'b0;
    set_cfg(1'b0, 1'b0, 1'b0, 24);
    run_cal(`MD_INT_ZERO, 4, 24'h000077);
    refuse(`MD_INT_FULL);
  endtask

  task automatic results();
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_coef();
    t_correct();
    t_cal();
    results();
  end
endmodule
